/* rtl/gpb_pkg.sv */
`default_nettype none
// shared constants for the general pin enable / direction bank
package gpb_pkg;

  // widths of the pin field and of the apb slave
  localparam int unsigned GPB_NUM_PINS  = 16;
  localparam int unsigned GPB_DATA_W    = 32;
  localparam int unsigned GPB_ADDR_W    = 32;
  localparam int unsigned GPB_STRB_W    = 4;
  localparam int unsigned GPB_LANE_W    = 8;
  localparam int unsigned GPB_PIN_LANES = 2;

  // register byte addresses
  localparam logic [31:0] GPB_ENABLE_ADDR     = 32'h01B0_0000;
  localparam logic [31:0] GPB_DIRECTION_ADDR  = 32'h01B0_0004;
  localparam logic [31:0] GPB_PIN_STATUS_ADDR = 32'h01B0_0040;

  // field positions: pin x is bit x, levels sit in the status upper half
  localparam int unsigned GPB_PIN_LSB          = 0;
  localparam int unsigned GPB_STATUS_LEVEL_LSB = 16;

  // reset values
  localparam logic [15:0] GPB_ENABLE_RST    = 16'h00F9;
  localparam logic [15:0] GPB_DIRECTION_RST = 16'h0000;
  localparam logic [15:0] GPB_RESERVED_ZERO = 16'h0000;
  localparam logic [31:0] GPB_RDATA_IDLE    = 32'h0000_0000;

  // per-pin bit meanings
  localparam logic GPB_PIN_ENABLED = 1'b1;
  localparam logic GPB_DIR_INPUT   = 1'b0;
  localparam logic GPB_DIR_OUTPUT  = 1'b1;

  // decoded register targets
  typedef enum {
    GPB_SEL_NONE,
    GPB_SEL_ENABLE,
    GPB_SEL_DIRECTION,
    GPB_SEL_STATUS
  } gpb_sel_e;

endpackage
`default_nettype wire

/* rtl/gpb_pin_cell.sv */
`timescale 1ns/10ps
`default_nettype none
// one general pin: steers the pad between the general function and the other function
module gpb_pin_cell
  import gpb_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // configuration bits
  input  wire logic enable_bit,
  input  wire logic direction_bit,
  // core side of the general function
  input  wire logic core_out,
  output logic      core_in,
  // other function sharing the pad
  input  wire logic alt_out,
  input  wire logic alt_oe,
  output logic      alt_in,
  // pad
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe
);

  typedef struct packed {
    logic pad_out;
    logic pad_oe;
    logic core_in;
    logic alt_in;
  } gpb_cell_state_s;

  gpb_cell_state_s state_reg;
  gpb_cell_state_s state_next;

  // pad ownership and drive
  always_comb
  begin
    state_next = state_reg;
    // [RQ2] enable hands pad
    if (enable_bit == GPB_PIN_ENABLED)
    begin
      // [RQ3] input never driven
      // [RQ4] output drives pad
      state_next.pad_oe  = (direction_bit == GPB_DIR_OUTPUT);
      state_next.pad_out = core_out;
      state_next.core_in = pad_in;
      state_next.alt_in  = 1'b0;
    end
    else
    begin
      // [RQ5] direction ignored here
      state_next.pad_oe  = alt_oe;
      state_next.pad_out = alt_out;
      state_next.core_in = 1'b0;
      state_next.alt_in  = pad_in;
    end
  end

  // state register, released pad after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign pad_out = state_reg.pad_out;
  assign pad_oe  = state_reg.pad_oe;
  assign core_in = state_reg.core_in;
  assign alt_in  = state_reg.alt_in;

endmodule
`default_nettype wire

/* rtl/gpb_bank.sv */
// What this block does
// [RQ1] sixteen general pins 0..15, pin x uses bit x of both registers
// [RQ2] a pin is general-purpose only while its enable bit is 1
// [RQ3] enabled pin with direction 0 is an input and is not driven
// [RQ4] enabled pin with direction 1 is driven as an output
// [RQ5] direction bit has no effect on a disabled pin
// [RQ6] all direction bits reset to 0, every enabled pin an input
// [RQ7] enable resets with bits 0,3,4,5,6,7 set, all others clear
// [RQ8] every enable and direction bit reads back the last value written
// [RQ9] enable register decoded at byte address 0x01B00000
// [RQ10] direction register decoded at byte address 0x01B00004
// [RQ11] bits 31..16 of both registers read zero and ignore writes
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module gpb_bank
(
  // clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // apb slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [gpb_pkg::GPB_ADDR_W-1:0]    paddr,
  input  wire logic [gpb_pkg::GPB_DATA_W-1:0]    pwdata,
  input  wire logic [gpb_pkg::GPB_STRB_W-1:0]    pstrb,
  output logic      [gpb_pkg::GPB_DATA_W-1:0]    prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // pad side of the general pins
  input  wire logic [gpb_pkg::GPB_NUM_PINS-1:0]  general_pins_in,
  output logic      [gpb_pkg::GPB_NUM_PINS-1:0]  general_pins_out,
  output logic      [gpb_pkg::GPB_NUM_PINS-1:0]  general_pins_oe,
  // core side of the general function
  input  wire logic [gpb_pkg::GPB_NUM_PINS-1:0]  gp_out_value,
  output logic      [gpb_pkg::GPB_NUM_PINS-1:0]  gp_in_value,
  // other function sharing the pads
  input  wire logic [gpb_pkg::GPB_NUM_PINS-1:0]  alt_out,
  input  wire logic [gpb_pkg::GPB_NUM_PINS-1:0]  alt_oe,
  output logic      [gpb_pkg::GPB_NUM_PINS-1:0]  alt_in
);
  import gpb_pkg::*;

  typedef struct packed {
    logic [GPB_NUM_PINS-1:0] per_pin_enable_bit;
    logic [GPB_NUM_PINS-1:0] per_pin_direction_bit;
    logic [GPB_DATA_W-1:0]   rdata;
    logic                    slverr;
    logic                    first_cycle;
  } gpb_bank_state_s;

  localparam gpb_bank_state_s GPB_STATE_RST = '{
    per_pin_enable_bit:    GPB_ENABLE_RST,
    per_pin_direction_bit: GPB_DIRECTION_RST,
    rdata:                 GPB_RDATA_IDLE,
    slverr:                1'b0,
    first_cycle:           1'b1
  };

  gpb_bank_state_s state_reg;
  gpb_bank_state_s state_next;

  gpb_sel_e                sel;
  logic                    setup_phase;
  logic                    access_phase;
  logic [GPB_NUM_PINS-1:0] pin_function_enable;
  logic [GPB_NUM_PINS-1:0] pin_direction_select;

  // address decode, full 32-bit compare
  function automatic gpb_sel_e decode_addr(input logic [GPB_ADDR_W-1:0] addr);
    gpb_sel_e s;
    s = GPB_SEL_NONE;
    case (addr)
      // [RQ9] enable register address
      GPB_ENABLE_ADDR:     s = GPB_SEL_ENABLE;
      // [RQ10] direction register address
      GPB_DIRECTION_ADDR:  s = GPB_SEL_DIRECTION;
      GPB_PIN_STATUS_ADDR: s = GPB_SEL_STATUS;
      default:             s = GPB_SEL_NONE;
    endcase
    return s;
  endfunction

  // byte-lane merge of a write into a pin field; lanes 2 and 3 hold nothing
  function automatic logic [GPB_NUM_PINS-1:0] merge_lanes(
    input logic [GPB_NUM_PINS-1:0] old_val,
    input logic [GPB_DATA_W-1:0]   wdata,
    input logic [GPB_STRB_W-1:0]   strb
  );
    logic [GPB_NUM_PINS-1:0] v;
    v = old_val;
    for (int l = 0; l < GPB_PIN_LANES; l++)
    begin
      if (strb[l])
        v[l*GPB_LANE_W +: GPB_LANE_W] = wdata[l*GPB_LANE_W +: GPB_LANE_W];
    end
    return v;
  endfunction

  // bus phases
  assign sel          = decode_addr(paddr);
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;

  assign pin_function_enable  = state_reg.per_pin_enable_bit;
  assign pin_direction_select = state_reg.per_pin_direction_bit;

  // register file next state
  always_comb
  begin
    state_next             = state_reg;
    state_next.first_cycle = 1'b0;
    // setup: prepare the answer so prdata comes from a flop
    if (setup_phase)
    begin
      state_next.rdata  = GPB_RDATA_IDLE;
      state_next.slverr = 1'b0;
      case (sel)
        GPB_SEL_ENABLE:
        begin
          // [RQ11] upper half reads zero
          if (!pwrite)
            state_next.rdata = {GPB_RESERVED_ZERO, pin_function_enable};
        end
        GPB_SEL_DIRECTION:
        begin
          if (!pwrite)
            state_next.rdata = {GPB_RESERVED_ZERO, pin_direction_select};
        end
        GPB_SEL_STATUS:
        begin
          if (pwrite)
            state_next.slverr = 1'b1;
          else
            state_next.rdata = {general_pins_in, general_pins_oe};
        end
        default:
          state_next.slverr = 1'b1;
      endcase
    end
    // access: write takes effect at the single completing edge
    if (access_phase && pwrite && !state_reg.slverr)
    begin
      // [RQ8] software writes bits
      // [RQ11] upper lanes ignored
      case (sel)
        GPB_SEL_ENABLE:
          state_next.per_pin_enable_bit =
            merge_lanes(state_reg.per_pin_enable_bit, pwdata, pstrb);
        GPB_SEL_DIRECTION:
          state_next.per_pin_direction_bit =
            merge_lanes(state_reg.per_pin_direction_bit, pwdata, pstrb);
        default:
          state_next.slverr = state_reg.slverr;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    // [RQ6] directions reset input
    // [RQ7] enable reset pattern
    if (!presetn)
      state_reg <= GPB_STATE_RST;
    else
      state_reg <= state_next;
  end

  // apb answer: zero wait states
  assign pready  = access_phase;
  assign pslverr = access_phase && state_reg.slverr;
  assign prdata  = state_reg.rdata;

  // one pad cell per pin
  // [RQ1] bit x drives pin x
  for (genvar i = 0; i < GPB_NUM_PINS; i++)
  begin : g_pin
    gpb_pin_cell u_cell (
      .pclk          (pclk),
      .presetn       (presetn),
      .enable_bit    (pin_function_enable[i]),
      .direction_bit (pin_direction_select[i]),
      .core_out      (gp_out_value[i]),
      .core_in       (gp_in_value[i]),
      .alt_out       (alt_out[i]),
      .alt_oe        (alt_oe[i]),
      .alt_in        (alt_in[i]),
      .pad_in        (general_pins_in[i]),
      .pad_out       (general_pins_out[i]),
      .pad_oe        (general_pins_oe[i])
    );
  end

  // checks on the behaviour above
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // reset contents seen at the first edge after release
  // [RQ6] [RQ7] reset defaults checked
  a_reset_defaults: assert property ( // [RQ7]
    state_reg.first_cycle |->
      pin_function_enable == GPB_ENABLE_RST && pin_direction_select == GPB_DIRECTION_RST)
    else $error("configuration not at reset defaults after reset");

  // full write to enable lands one edge later
  // [RQ8] [RQ9] enable write stored
  a_enable_write: assert property ( // [RQ9]
    (access_phase && pwrite && sel == GPB_SEL_ENABLE && pstrb[1:0] == 2'b11)
      |=> pin_function_enable == $past(pwdata[GPB_NUM_PINS-1:0]))
    else $error("enable register did not take written value");

  // single lane write leaves the other lane alone
  // [RQ8] lane merge checked
  a_direction_lane: assert property ( // [RQ8]
    (access_phase && pwrite && sel == GPB_SEL_DIRECTION && pstrb[1:0] == 2'b01)
      |=> pin_direction_select[15:8] == $past(pin_direction_select[15:8])
       && pin_direction_select[7:0] == $past(pwdata[7:0]))
    else $error("direction lane write merged wrongly");

  // read answer in the access cycle after setup
  // [RQ10] direction read back
  a_direction_read: assert property ( // [RQ10]
    (setup_phase && !pwrite && sel == GPB_SEL_DIRECTION) ##1 access_phase
      |-> pready && !pslverr && prdata == {GPB_RESERVED_ZERO, pin_direction_select})
    else $error("direction read returned wrong data");

  // reserved upper half reads zero
  // [RQ11] reserved bits zero
  a_reserved_zero: assert property ( // [RQ11]
    (access_phase && !pwrite && (sel == GPB_SEL_ENABLE || sel == GPB_SEL_DIRECTION))
      |-> prdata[31:16] == GPB_RESERVED_ZERO)
    else $error("reserved bits read nonzero");

  // unmapped address answers with an error and no data
  a_unmapped_error: assert property (
    (setup_phase && sel == GPB_SEL_NONE) ##1 access_phase
      |-> pslverr && prdata == GPB_RDATA_IDLE)
    else $error("unmapped access not flagged");

  // enabled inputs never driven
  // [RQ3] input not driven
  a_input_undriven: assert property ( // [RQ3]
    (general_pins_oe & $past(pin_function_enable & ~pin_direction_select)) == '0)
    else $error("enabled input pin is being driven");

  // enabled outputs driven with the core value
  // [RQ4] [RQ1] output driven
  a_output_driven: assert property ( // [RQ4]
    ((general_pins_oe & $past(pin_function_enable & pin_direction_select))
        == $past(pin_function_enable & pin_direction_select))
     && (((general_pins_out ^ $past(gp_out_value))
        & $past(pin_function_enable & pin_direction_select)) == '0))
    else $error("enabled output pin not driven with core value");

  // disabled pins follow the other function whatever the direction bit
  // [RQ2] [RQ5] disabled pin untouched
  a_disabled_alt: assert property ( // [RQ5]
    !state_reg.first_cycle |->
      (((general_pins_oe ^ $past(alt_oe)) & ~$past(pin_function_enable)) == '0)
       && ((gp_in_value & ~$past(pin_function_enable)) == '0))
    else $error("disabled pin not left to its other function");

  // enable read answer in the access cycle after setup
  // [RQ9] enable read back
  a_enable_read: assert property ( // [RQ9]
    (setup_phase && !pwrite && sel == GPB_SEL_ENABLE) ##1 access_phase
      |-> pready && !pslverr && prdata == {GPB_RESERVED_ZERO, pin_function_enable})
    else $error("enable read returned wrong data");

  // full write to direction lands one edge later
  // [RQ8] [RQ10] direction write stored
  a_direction_write: assert property ( // [RQ10]
    (access_phase && pwrite && sel == GPB_SEL_DIRECTION && pstrb[1:0] == 2'b11)
      |=> pin_direction_select == $past(pwdata[GPB_NUM_PINS-1:0]))
    else $error("direction register did not take written value");

  // writes to the read-only status word are refused and change nothing
  // [RQ8] refused write harmless
  a_status_refused: assert property ( // [RQ8]
    (access_phase && pwrite && sel == GPB_SEL_STATUS)
      |-> pslverr ##1 ($stable(pin_function_enable) && $stable(pin_direction_select)))
    else $error("status write not refused");

  // status word holds the pad levels and drive enables seen at setup
  // [RQ1] status read back
  a_status_read: assert property ( // [RQ1]
    (setup_phase && !pwrite && sel == GPB_SEL_STATUS) ##1 access_phase
      |-> !pslverr && prdata == {$past(general_pins_in), $past(general_pins_oe)})
    else $error("status read returned wrong data");

  // pads stay released while the configuration leaves reset
  // [RQ6] pads released after reset
  a_reset_pads: assert property ( // [RQ6]
    state_reg.first_cycle |-> general_pins_oe == '0 && gp_in_value == '0)
    else $error("pad driven straight after reset");

  // main scenarios
  c_enable_write: cover property (
    access_phase && pwrite && sel == GPB_SEL_ENABLE);
  c_pin_to_output: cover property (
    (access_phase && pwrite && sel == GPB_SEL_DIRECTION) ##2 (general_pins_oe != '0));
  c_status_read: cover property (
    access_phase && !pwrite && sel == GPB_SEL_STATUS);
  c_unmapped: cover property (
    access_phase && pslverr);
  c_direction_lane: cover property (
    access_phase && pwrite && sel == GPB_SEL_DIRECTION && pstrb[1:0] == 2'b01);

endmodule
`default_nettype wire

/* sim/gpb_board_model.sv */
`timescale 1ns/10ps
`default_nettype none
// board side of the sixteen pads
module gpb_board_model
(
  // device drive
  input  wire logic [gpb_pkg::GPB_NUM_PINS-1:0] pad_out,
  input  wire logic [gpb_pkg::GPB_NUM_PINS-1:0] pad_oe,
  // board drive
  input  wire logic [gpb_pkg::GPB_NUM_PINS-1:0] board_val,
  // level seen back at the device
  output logic      [gpb_pkg::GPB_NUM_PINS-1:0] pad_in
);
  import gpb_pkg::*;
  // board gives way wherever the device drives, so no contention
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_val);
endmodule
`default_nettype wire

/* sim/tb_gpio_enable_direction_bank.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_gpio_enable_direction_bank;
  import gpb_pkg::*;
  // bench signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] pins_in, pins_out, pins_oe, gp_in, alt_in;
  logic [15:0] gp_out = '0;
  logic [15:0] alt_o = '0;
  logic [15:0] alt_e = '0;
  logic [15:0] board = '0;
  logic [15:0] en_m = 16'h00F9;
  logic [15:0] dir_m = 16'h0000;
  logic [15:0] oe_x = '0;
  logic [15:0] pad_x = '0;
  logic [1:0]  lanes = 2'b11;
  logic [32:0] exp_q[$];
  logic [32:0] got;
  logic [31:0] d;
  integer      seed = 32'h3755;
  int          n_errors = 0;
  int          checks = 0;

  // clock
  always #10 pclk = ~pclk;

  gpb_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .general_pins_in(pins_in),
    .general_pins_out(pins_out), .general_pins_oe(pins_oe), .gp_out_value(gp_out),
    .gp_in_value(gp_in), .alt_out(alt_o), .alt_oe(alt_e), .alt_in(alt_in));

  gpb_board_model board_m (.pad_out(pins_out), .pad_oe(pins_oe), .board_val(board),
    .pad_in(pins_in));

  // verdict and end of run
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one comparison
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, expected {pslverr, prdata} noted at setup
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= {2'($random(seed)), lanes};
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until pready is seen; only the hang guard ends a lost answer
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // random pad stimulus, then pad outputs against the model
  task automatic pin_chk;
    logic [15:0] oe_e, drv_e, pad_e;
    @(posedge pclk);
    gp_out <= 16'($random(seed));
    alt_o <= 16'($random(seed));
    alt_e <= 16'($random(seed));
    board <= 16'($random(seed));
    repeat (3) @(posedge pclk);
    #1;
    oe_e = (en_m & dir_m) | (~en_m & alt_e);
    drv_e = (en_m & dir_m & gp_out) | (~en_m & alt_e & alt_o);
    pad_e = drv_e | (~oe_e & board);
    oe_x = oe_e;
    pad_x = pad_e;
    chk("pin drive enable", {17'h0, oe_e}, {17'h0, pins_oe});
    chk("pin drive value", {17'h0, drv_e}, {17'h0, pins_out & oe_e});
    chk("general input", {17'h0, pad_e & en_m}, {17'h0, gp_in});
    chk("other input", {17'h0, pad_e & ~en_m}, {17'h0, alt_in});
  endtask

  // answer watcher: oldest note against each completed transfer
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      got = exp_q.pop_front();
      chk("apb answer", got, {pslverr, prdata});
    end

  // hang guard
  initial
  begin
    #100us;
    n_errors++;
    finish_test;
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    pin_chk;
    apb(1'b0, GPB_ENABLE_ADDR, 32'h0, 33'h0_0000_00F9);
    apb(1'b0, GPB_DIRECTION_ADDR, 32'h0, 33'h0);
    // random writes, read back and pad effect
    for (int i = 0; i < 12; i++)
    begin
      d = $random(seed);
      apb(1'b1, GPB_ENABLE_ADDR + 32'(4 * (i % 2)), d, 33'h0);
      if (i % 2 == 1)
        dir_m = d[15:0];
      else
        en_m = d[15:0];
      apb(1'b0, GPB_ENABLE_ADDR + 32'(4 * (i % 2)), 32'h0, {17'h0, d[15:0]});
      pin_chk;
    end
    // status word against the pad model
    apb(1'b0, GPB_PIN_STATUS_ADDR, 32'h0, {1'b0, pad_x, oe_x});
    // low lane only: the high pin byte keeps its value
    lanes = 2'b01;
    d = $random(seed);
    apb(1'b1, GPB_DIRECTION_ADDR, d, 33'h0);
    dir_m[7:0] = d[7:0];
    lanes = 2'b11;
    apb(1'b0, GPB_DIRECTION_ADDR, 32'h0, {17'h0, dir_m});
    pin_chk;
    // refused accesses leave the registers alone
    apb(1'b0, 32'h01B0_0008, 32'h0, 33'h1_0000_0000);
    apb(1'b1, GPB_PIN_STATUS_ADDR, 32'hFFFF_FFFF, 33'h1_0000_0000);
    apb(1'b1, 32'h01B1_0000, 32'hFFFF_FFFF, 33'h1_0000_0000);
    apb(1'b0, GPB_ENABLE_ADDR, 32'h0, {17'h0, en_m});
    apb(1'b0, GPB_DIRECTION_ADDR, 32'h0, {17'h0, dir_m});
    // second reset in mid-run restores defaults
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    en_m = 16'h00F9;
    dir_m = 16'h0000;
    apb(1'b0, GPB_ENABLE_ADDR, 32'h0, 33'h0_0000_00F9);
    apb(1'b0, GPB_DIRECTION_ADDR, 32'h0, 33'h0);
    pin_chk;
    chk("notes left", 33'h0, 33'(exp_q.size()));
    finish_test;
  end
endmodule
`default_nettype wire
